// [rtl/ptab_pkg.sv]
package ptab_pkg;
   localparam int unsigned PTAB_ADDR_W        = 16;
   localparam int unsigned PTAB_WORD_W        = 16;
   localparam int unsigned PTAB_BYTE_W        = 8;
   localparam logic [15:0] PTAB_PTR_RST       = 16'h0000;
   localparam logic [15:0] PTAB_LATCH_RST     = 16'h0000;
   localparam int unsigned PTAB_CLK_PERIOD_NS = 10;
   // Write that fails the programming voltage check lasts this many cycles
   localparam int unsigned PTAB_NOVPP_CYCLES  = 2;
   localparam int unsigned PTAB_EXT_CYCLES    = 2;
   typedef enum logic [2:0] {
      PTAB_OP_NONE,
      PTAB_OP_LATCH_RD,
      PTAB_OP_LATCH_WR,
      PTAB_OP_TABLE_RD,
      PTAB_OP_TABLE_WR
   } ptab_op_t;
   typedef enum {
      PTAB_IDLE,
      PTAB_RD_FETCH,
      PTAB_LONG_WR,
      PTAB_SHORT_WR,
      PTAB_EXT_WR
   } ptab_state_t;
endpackage : ptab_pkg

// [rtl/ptab_table_access.sv]
// Behaviour
// RULE_01: Table read first copies selected latch byte to destination data register.
// RULE_02: Table read then loads program word at pointer into the latch.
// RULE_03: Increment operand 1 bumps pointer after access; 0 leaves it.
// RULE_04: First read after pointer load returns stale latch data, a dummy.
// RULE_05: Internal table write starts long write that halts execution.
// RULE_06: Long write ends only on reset or enabled and flagged interrupt.
// RULE_07: Global interrupt disable does not affect termination, only vectoring.
// RULE_08: Disable 0 vectors after termination; disable 1 continues without vectoring.
// RULE_09: Pin or timer source ending long write gets highest-priority flag cleared.
// RULE_10: Peripheral source ending long write keeps its flag set.
// RULE_11: Enabled interrupt pending at write start aborts it as no-op, clears flag.
// RULE_12: Without programming voltage internal write takes 2 cycles, memory unchanged.
// RULE_13: External table write takes two cycles, data written in second.
// RULE_14: Interrupts never shorten external write; afterwards clear flag or acknowledge.
// RULE_15: External accesses use separate read and write latches.
// RULE_16: Software loads write latch with latch write before external table write.
// RULE_17: Software disables other interrupts, raises voltage, clears watchdog, writes, verifies.
// RULE_18: Software disables interrupts not used to time the program write.
// RULE_19: Table write stores full 16-bit latch into word at pointer.
// RULE_20: Pointer is two 8-bit registers forming a 16-bit address.
// RULE_21: Byte select 1 picks high latch byte, 0 the low byte.
// RULE_22: Table write places source byte into selected latch half first.
`timescale 1ns/10ps
`default_nettype none
module ptab_table_access
   import ptab_pkg::*;
#(
   parameter int unsigned ADDR_W = PTAB_ADDR_W,
   parameter int unsigned WORD_W = PTAB_WORD_W
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire ptab_op_t            opCode,
   input  wire logic                byteSelHigh,
   input  wire logic                incPointer,
   input  wire logic [7:0]          srcData,
   input  wire logic                ptrLowWrite,
   input  wire logic                ptrHighWrite,
   input  wire logic                extMemSel,
   input  wire logic                progVoltageOk,
   input  wire logic                globalInterruptDisable,
   input  wire logic [2:0]          pinTimerEnable,
   input  wire logic [2:0]          pinTimerFlag,
   input  wire logic                periphEnable,
   input  wire logic                periphFlag,
   input  wire logic [WORD_W-1:0]   memRdData,
   output var  logic [ADDR_W-1:0]   memAddr,
   output logic                     memRdEn,
   output logic                     memWrEn,
   output var  logic [WORD_W-1:0]   memWrData,
   output logic                     memIsExternal,
   output var  logic [7:0]          destData,
   output var  logic                destValid,
   output logic                     execHalt,
   output var  logic                vectorReq,
   output var  logic [2:0]          flagClear,
   output var  logic                periphAck,
   output logic [ADDR_W-1:0]        tablePointer
);
   // Pointer, latch and word datapaths are fixed at 16 bits
   if (ADDR_W != 16 || WORD_W != 16) begin : g_badWidth
      $error("ptab: only 16-bit address and word supported");
   end

   // Index 0 of pinTimerFlag is highest priority
   function automatic logic [2:0] ptabPickHighest(input logic [2:0] req);
      logic [2:0] r;
      r = 3'h0;
      if (req[0]) r = 3'h1;
      else if (req[1]) r = 3'h2;
      else if (req[2]) r = 3'h4;
      return r;
   endfunction

   ptab_state_t      state_ff, nxt_state;
   logic [15:0]      ptr_ff, nxt_ptr;
   logic [15:0]      rdLatch_ff, nxt_rdLatch;
   logic [15:0]      wrLatch_ff, nxt_wrLatch;
   logic             ptrFresh_ff, nxt_ptrFresh;
   logic             inc_ff, nxt_inc;
   logic             ext_ff, nxt_ext;
   logic [7:0]       destData_ff, nxt_destData;
   logic             destValid_ff, nxt_destValid;
   logic             vector_ff, nxt_vector;
   logic [2:0]       flagClr_ff, nxt_flagClr;
   logic             pAck_ff, nxt_pAck;
   logic [15:0]      memAddr_ff, nxt_memAddr;
   logic [15:0]      memWrData_ff, nxt_memWrData;
   logic             destStale;

   logic [2:0] ptActive;
   logic       irqTerm;
   assign ptActive = pinTimerEnable & pinTimerFlag;
   assign irqTerm  = (|ptActive) | (periphEnable & periphFlag); // RULE_06 RULE_07

   // Latch after writing the selected byte, shared by internal and external accesses
   logic [15:0] latchIn, wrLatchSel;
   always_comb begin
      wrLatchSel = ext_ff ? wrLatch_ff : rdLatch_ff;
      if (extMemSel) wrLatchSel = wrLatch_ff; // RULE_15
      else           wrLatchSel = rdLatch_ff;
      latchIn = wrLatchSel;
      if (byteSelHigh) latchIn[15:8] = srcData; // RULE_21 RULE_22
      else             latchIn[7:0]  = srcData;
   end

   always_comb begin
      nxt_state     = state_ff;
      nxt_ptr       = ptr_ff;
      nxt_rdLatch   = rdLatch_ff;
      nxt_wrLatch   = wrLatch_ff;
      nxt_ptrFresh  = ptrFresh_ff;
      nxt_inc       = inc_ff;
      nxt_ext       = ext_ff;
      nxt_destData  = destData_ff;
      nxt_destValid = 1'b0;
      nxt_vector    = 1'b0;
      nxt_flagClr   = 3'h0;
      nxt_pAck      = 1'b0;
      nxt_memAddr   = memAddr_ff;
      nxt_memWrData = memWrData_ff;
      if (ptrLowWrite)  nxt_ptr[7:0]  = srcData; // RULE_20
      if (ptrHighWrite) nxt_ptr[15:8] = srcData; // RULE_20
      case (state_ff)
         PTAB_IDLE: begin
            nxt_ext = extMemSel;
            nxt_inc = incPointer;
            case (opCode)
               PTAB_OP_LATCH_RD: begin
                  nxt_destData  = byteSelHigh ? rdLatch_ff[15:8] : rdLatch_ff[7:0]; // RULE_21
                  nxt_destValid = 1'b1;
               end
               PTAB_OP_LATCH_WR: begin
                  if (extMemSel) nxt_wrLatch = latchIn; // RULE_15
                  else           nxt_rdLatch = latchIn;
               end
               PTAB_OP_TABLE_RD: begin
                  // Old latch byte goes out before the fetch overwrites it
                  nxt_destData  = byteSelHigh ? rdLatch_ff[15:8] : rdLatch_ff[7:0]; // RULE_01 RULE_04
                  nxt_destValid = 1'b1;
                  nxt_memAddr   = ptr_ff;
                  nxt_state     = PTAB_RD_FETCH;
               end
               PTAB_OP_TABLE_WR: begin
                  if (extMemSel) nxt_wrLatch = latchIn; // RULE_22
                  else           nxt_rdLatch = latchIn;
                  nxt_memAddr   = ptr_ff;
                  nxt_memWrData = latchIn; // RULE_19
                  if (extMemSel) begin
                     nxt_state = PTAB_EXT_WR; // RULE_13 RULE_14
                  end else if (irqTerm) begin
                     nxt_flagClr = ptabPickHighest(ptActive); // RULE_11
                  end else if (!progVoltageOk) begin
                     nxt_state = PTAB_SHORT_WR; // RULE_12
                  end else begin
                     nxt_state = PTAB_LONG_WR; // RULE_05
                  end
               end
               default: ;
            endcase
         end
         PTAB_RD_FETCH: begin
            nxt_rdLatch  = memRdData; // RULE_02
            nxt_ptrFresh = 1'b0;
            if (inc_ff) nxt_ptr = ptr_ff + 16'h0001; // RULE_03
            nxt_state = PTAB_IDLE;
         end
         PTAB_LONG_WR: begin
            if (irqTerm) begin // RULE_06
               nxt_vector  = !globalInterruptDisable; // RULE_08
               nxt_flagClr = ptabPickHighest(ptActive); // RULE_09 RULE_10
               if (inc_ff) nxt_ptr = ptr_ff + 16'h0001; // RULE_03
               nxt_state = PTAB_IDLE;
            end
         end
         PTAB_SHORT_WR: begin
            if (inc_ff) nxt_ptr = ptr_ff + 16'h0001;
            nxt_state = PTAB_IDLE;
         end
         PTAB_EXT_WR: begin
            nxt_flagClr = ptabPickHighest(ptActive); // RULE_14
            nxt_pAck    = (ptActive == 3'h0) && periphEnable && periphFlag;
            if (inc_ff) nxt_ptr = ptr_ff + 16'h0001; // RULE_03
            nxt_state = PTAB_IDLE;
         end
         default: nxt_state = PTAB_IDLE;
      endcase
      // A pointer load always wins over the fetch clearing the stale mark
      if (ptrLowWrite || ptrHighWrite) nxt_ptrFresh = 1'b1; // RULE_04
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= PTAB_IDLE;
         ptr_ff       <= PTAB_PTR_RST;
         rdLatch_ff   <= PTAB_LATCH_RST;
         wrLatch_ff   <= PTAB_LATCH_RST;
         ptrFresh_ff  <= 1'b1;
         inc_ff       <= 1'b0;
         ext_ff       <= 1'b0;
         destData_ff  <= 8'h00;
         destValid_ff <= 1'b0;
         vector_ff    <= 1'b0;
         flagClr_ff   <= 3'h0;
         pAck_ff      <= 1'b0;
         memAddr_ff   <= 16'h0000;
         memWrData_ff <= 16'h0000;
      end else begin
         state_ff     <= nxt_state;
         ptr_ff       <= nxt_ptr;
         rdLatch_ff   <= nxt_rdLatch;
         wrLatch_ff   <= nxt_wrLatch;
         ptrFresh_ff  <= nxt_ptrFresh;
         inc_ff       <= nxt_inc;
         ext_ff       <= nxt_ext;
         destData_ff  <= nxt_destData;
         destValid_ff <= nxt_destValid;
         vector_ff    <= nxt_vector;
         flagClr_ff   <= nxt_flagClr;
         pAck_ff      <= nxt_pAck;
         memAddr_ff   <= nxt_memAddr;
         memWrData_ff <= nxt_memWrData;
      end
   end

   assign destStale     = ptrFresh_ff; // RULE_04
   assign memAddr       = memAddr_ff;
   assign memWrData     = memWrData_ff;
   assign memRdEn       = (state_ff == PTAB_RD_FETCH);
   // Long write drives the strobe throughout; short write never touches memory
   assign memWrEn       = (state_ff == PTAB_LONG_WR) || (state_ff == PTAB_EXT_WR); // RULE_13
   assign memIsExternal = ext_ff;
   assign execHalt      = (state_ff != PTAB_IDLE); // RULE_05
   assign destData      = destData_ff;
   assign destValid     = destValid_ff;
   assign vectorReq     = vector_ff;
   assign flagClear     = flagClr_ff;
   assign periphAck     = pAck_ff;
   assign tablePointer  = ptr_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_extStart;
      state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_WR && extMemSel;
   endsequence

   a_ext_two_cycle: assert property (s_extStart |=> memWrEn ##1 !execHalt) // RULE_13
      else $error("external write not two cycles");
   a_ext_no_abort: assert property (s_extStart |=> state_ff == PTAB_EXT_WR) // RULE_14
      else $error("external write shortened");
   a_long_start: assert property (state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_WR && !extMemSel // RULE_05
      && !irqTerm && progVoltageOk |=> execHalt && state_ff == PTAB_LONG_WR)
      else $error("long write not started");
   a_long_hold: assert property (state_ff == PTAB_LONG_WR && !irqTerm |=> state_ff == PTAB_LONG_WR) // RULE_06
      else $error("long write ended without interrupt");
   a_vector_sel: assert property (state_ff == PTAB_LONG_WR && irqTerm // RULE_07 RULE_08
      |=> !execHalt && vectorReq == !$past(globalInterruptDisable))
      else $error("vector choice wrong");
   a_periph_keep: assert property (state_ff == PTAB_LONG_WR && irqTerm && ptActive == 3'h0 // RULE_10
      |=> flagClear == 3'h0)
      else $error("peripheral flag cleared");
   a_pending_abort: assert property (state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_WR && !extMemSel // RULE_11
      && irqTerm |=> !execHalt && !memWrEn)
      else $error("pending interrupt did not abort");
   a_short_write: assert property (state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_WR && !extMemSel // RULE_12
      && !irqTerm && !progVoltageOk |=> execHalt && !memWrEn ##1 !execHalt)
      else $error("short write wrong");
   a_read_inc: assert property (state_ff == PTAB_RD_FETCH && !ptrLowWrite && !ptrHighWrite // RULE_03
      |=> tablePointer == $past(ptr_ff) + ($past(inc_ff) ? 16'h0001 : 16'h0000))
      else $error("pointer step wrong");
   a_read_copy: assert property (state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_RD // RULE_01 RULE_02
      |=> destValid && destData == ($past(byteSelHigh) ? $past(rdLatch_ff[15:8]) : $past(rdLatch_ff[7:0]))
      ##1 rdLatch_ff == $past(memRdData))
      else $error("table read sequence wrong");

   sequence s_extRead;
      state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_RD && extMemSel;
   endsequence

   sequence s_intWrStart;
      state_ff == PTAB_IDLE && opCode == PTAB_OP_TABLE_WR && !extMemSel;
   endsequence

   a_latch_split: assert property (s_extRead |-> ##2 wrLatch_ff == $past(wrLatch_ff, 2)) // RULE_15
      else $error("table read disturbed write latch");
   // Lowest set bit of the active sources is the highest priority one
   a_pin_clear: assert property (state_ff == PTAB_LONG_WR && (|ptActive) // RULE_09
      |=> flagClear == ($past(ptActive) & (~$past(ptActive) + 3'h1)))
      else $error("wrong pin or timer flag cleared");
   a_abort_clear: assert property (s_intWrStart ##0 (|ptActive) // RULE_11
      |=> flagClear == ($past(ptActive) & (~$past(ptActive) + 3'h1)))
      else $error("wrong flag cleared on abort");
   a_abort_ptr: assert property (s_intWrStart ##0 (irqTerm && !ptrLowWrite && !ptrHighWrite) // RULE_11
      |=> tablePointer == $past(ptr_ff))
      else $error("pointer moved on aborted write");
   a_ext_ack: assert property (state_ff == PTAB_EXT_WR && ptActive == 3'h0 && periphEnable && periphFlag // RULE_14
      |=> periphAck)
      else $error("peripheral not acknowledged");
   a_stale_mark: assert property (ptrLowWrite || ptrHighWrite |=> destStale) // RULE_04
      else $error("pointer load not marked stale");
   a_stale_clear: assert property (state_ff == PTAB_RD_FETCH && !ptrLowWrite && !ptrHighWrite // RULE_04
      |=> !destStale)
      else $error("fetch left stale mark");
   a_long_data: assert property (state_ff == PTAB_LONG_WR |-> memWrEn && memWrData == rdLatch_ff) // RULE_19
      else $error("long write data not latch");
   a_vector_src: assert property (vectorReq |-> $past(state_ff) == PTAB_LONG_WR) // RULE_08
      else $error("vector without long write");
endmodule // ptab_table_access
`default_nettype wire

// [test/ptab_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ptab_mem_model
   import ptab_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic [15:0] memAddr,
   input  wire logic        memRdEn,
   input  wire logic        memWrEn,
   input  wire logic [15:0] memWrData,
   output logic      [15:0] memRdData
);
   logic [15:0] mem [256];
   logic [15:0] junk;
   initial begin
      junk = 16'h0000;
      for (int a = 0; a < 256; a++) begin
         mem[a] = {a[7:0] ^ 8'ha5, a[7:0] + 8'h3c};
      end
   end
   // Idle bus churns so a stale word never looks valid
   always @(posedge ref_clk) begin
      junk <= ~junk ^ 16'h1234;
      if (memWrEn) begin
         mem[memAddr[7:0]] <= memWrData;
      end
   end
   assign memRdData = memRdEn ? mem[memAddr[7:0]] : junk;
endmodule // ptab_mem_model
`default_nettype wire

// [test/test_ptab_table_access.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module test_ptab_table_access import ptab_pkg::*;;
   logic ref_clk, rst_n, byteSelHigh, incPointer, ptrLowWrite, ptrHighWrite, extMemSel;
   logic progVoltageOk, globalInterruptDisable, periphEnable, periphFlag, memRdEn, memWrEn;
   logic memIsExternal, destValid, execHalt, vectorReq, periphAck, vecOr, ackOr, extSeen;
   ptab_op_t    opCode;
   logic [7:0]  srcData, destData, dSeen, h, l;
   logic [2:0]  pinTimerEnable, pinTimerFlag, flagClear, fcOr;
   logic [15:0] memRdData, memAddr, memWrData, tablePointer, wrData, wrAddr, p, w;
   int          seed, error_cnt, samples_checked, wrCnt, haltCnt;

   ptab_table_access dut (.ref_clk, .rst_n, .opCode, .byteSelHigh, .incPointer, .srcData,
      .ptrLowWrite, .ptrHighWrite, .extMemSel, .progVoltageOk, .globalInterruptDisable,
      .pinTimerEnable, .pinTimerFlag, .periphEnable, .periphFlag, .memRdData, .memAddr,
      .memRdEn, .memWrEn, .memWrData, .memIsExternal, .destData, .destValid, .execHalt,
      .vectorReq, .flagClear, .periphAck, .tablePointer);
   ptab_mem_model mem (.ref_clk, .memAddr, .memRdEn, .memWrEn, .memWrData, .memRdData);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] memWord(input logic [15:0] a);
      return {a[7:0] ^ 8'ha5, a[7:0] + 8'h3c};
   endfunction

   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic ptrLoad(input logic [15:0] a);
      @(negedge ref_clk);
      srcData = a[7:0];
      ptrLowWrite = 1'b1;
      @(negedge ref_clk);
      ptrLowWrite = 1'b0;
      srcData = a[15:8];
      ptrHighWrite = 1'b1;
      @(negedge ref_clk);
      ptrHighWrite = 1'b0;
   endtask

   // Flags given here rise termAt cycles into the access; -1 keeps the preset ones
   task automatic op(input ptab_op_t c, input logic s, input logic i, input logic e,
                     input int termAt, input logic [2:0] tf, input logic pf);
      dSeen = 8'h00; wrCnt = 0; haltCnt = 0; fcOr = 3'h0; vecOr = 1'b0;
      ackOr = 1'b0; extSeen = 1'b0;
      @(negedge ref_clk);
      opCode = c; byteSelHigh = s; incPointer = i; extMemSel = e;
      for (int k = 0; k < 400; k++) begin
         @(negedge ref_clk);
         opCode = PTAB_OP_NONE;
         if (k == termAt) begin
            pinTimerFlag = tf;
            periphFlag = pf;
         end
         if (destValid === 1'b1) dSeen = destData;
         if (memWrEn === 1'b1) begin
            wrCnt++; wrData = memWrData; wrAddr = memAddr;
            extSeen = memIsExternal;
         end
         fcOr = fcOr | flagClear;
         vecOr = vecOr | vectorReq;
         ackOr = ackOr | periphAck;
         pinTimerFlag = pinTimerFlag & ~flagClear;
         if (execHalt === 1'b1) haltCnt++;
         else if (k > termAt + 3) break;
      end
      pinTimerFlag = 3'h0;
      periphFlag = 1'b0;
   endtask

   initial begin
      seed = 69; error_cnt = 0; samples_checked = 0; rst_n = 1'b0; opCode = PTAB_OP_NONE;
      byteSelHigh = 0; incPointer = 0; srcData = 8'h00; ptrLowWrite = 0; ptrHighWrite = 0;
      extMemSel = 0; progVoltageOk = 1; globalInterruptDisable = 1; periphEnable = 0;
      periphFlag = 0; pinTimerEnable = 3'h0; pinTimerFlag = 3'h0;
      repeat (16) @(negedge ref_clk);
      `CHK("ptr_rst", PTAB_PTR_RST, tablePointer)
      rst_n = 1'b1;
      for (int r = 0; r < 4; r++) begin
         p = 16'($random(seed));
         ptrLoad(p);
         `CHK("ptr_load", p, tablePointer)
         op(PTAB_OP_TABLE_RD, 0, 1, 0, -1, 3'h0, 0);
         `CHK("ptr_inc", p + 16'h1, tablePointer)
         op(PTAB_OP_TABLE_RD, 1, 0, 0, -1, 3'h0, 0);
         w = memWord(p);
         `CHK("rd_hi", w[15:8], dSeen)
         `CHK("ptr_hold", p + 16'h1, tablePointer)
         op(PTAB_OP_TABLE_RD, 0, 1, 0, -1, 3'h0, 0);
         w = memWord(p + 16'h1);
         `CHK("rd_lo", w[7:0], dSeen)
      end
      pinTimerEnable = 3'b110;
      periphEnable = 1'b1;
      for (int r = 0; r < 3; r++) begin
         p = 16'($random(seed)); h = 8'($random(seed)); l = 8'($random(seed));
         ptrLoad(p);
         srcData = h;
         op(PTAB_OP_LATCH_WR, 1, 0, 1, -1, 3'h0, 0);
         srcData = l;
         pinTimerFlag = (r == 0) ? 3'b110 : 3'h0;
         periphFlag = (r == 1);
         op(PTAB_OP_TABLE_WR, 0, 1, 1, -1, 3'h0, 0);
         `CHK("ext_wr_cnt", 1, wrCnt)
         `CHK("ext_wr_len", 1, haltCnt)
         `CHK("ext_wr_data", {h, l}, wrData)
         `CHK("ext_wr_addr", p, wrAddr)
         `CHK("ext_flag_clr", (r == 0) ? 3'b010 : 3'b000, fcOr)
         `CHK("ext_ack", r == 1, ackOr)
         `CHK("ext_mem_sel", 1'b1, extSeen)
         op(PTAB_OP_TABLE_RD, 0, 0, 1, -1, 3'h0, 0);
         op(PTAB_OP_TABLE_WR, 0, 0, 1, -1, 3'h0, 0);
         `CHK("ext_wr_latch", {h, l}, wrData)
      end
      for (int k = 0; k < 4; k++) begin
         globalInterruptDisable = k[0];
         // Only the source that times the write is enabled
         pinTimerEnable = k[1] ? 3'b010 : 3'b000;
         periphEnable = !k[1];
         p = 16'($random(seed));
         l = 8'($random(seed));
         ptrLoad(p);
         srcData = l;
         op(PTAB_OP_TABLE_WR, 0, 1, 0, 8, k[1] ? 3'b110 : 3'h0, !k[1]);
         `CHK("long_len", 1'b1, haltCnt >= 8)
         `CHK("long_vector", !k[0], vecOr)
         `CHK("long_flag_clr", k[1] ? 3'b010 : 3'b000, fcOr)
         `CHK("long_ptr", p + 16'h1, tablePointer)
         `CHK("long_int", 1'b0, extSeen)
         ptrLoad(p);
         op(PTAB_OP_TABLE_RD, 0, 0, 0, -1, 3'h0, 0);
         op(PTAB_OP_TABLE_RD, 0, 1, 0, -1, 3'h0, 0);
         `CHK("long_verify", l, dSeen)
      end
      pinTimerEnable = 3'b111;
      pinTimerFlag = 3'b100;
      op(PTAB_OP_TABLE_WR, 0, 1, 0, -1, 3'h0, 0);
      `CHK("abort_wr", 0, wrCnt)
      `CHK("abort_flag_clr", 3'b100, fcOr)
      `CHK("abort_ptr", p + 16'h1, tablePointer)
      progVoltageOk = 1'b0;
      op(PTAB_OP_TABLE_WR, 0, 0, 0, -1, 3'h0, 0);
      `CHK("novpp_len", PTAB_NOVPP_CYCLES - 1, haltCnt)
      `CHK("novpp_wr", 0, wrCnt)
      conclude();
   end

   // Whole sequence needs well under 2000 cycles
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
endmodule // test_ptab_table_access
`default_nettype wire
